/* rtl/timer_pkg.sv */
// Purpose: Shared constants for the paired general-purpose timer block.
// Assumes: AXI4-Lite register access, 32-bit data, one clock domain.
// Notes: Register offsets are byte addresses.
package timer_pkg;

	// Register bus geometry
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFF_CTRL_EVEN = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_COUNT_EVEN = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_CTRL_ODD = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_COUNT_ODD = 8'h0C;

	// Control register field positions
	localparam int BIT_ON = 15;
	localparam int BIT_IDLE_STOP = 13;
	localparam int BIT_GATE = 7;
	localparam int PRESCALE_MSB = 6;
	localparam int PRESCALE_LSB = 4;
	localparam int BIT_PAIR = 3;
	localparam int BIT_CLK_SRC = 1;

	// Implemented control bits of each timer
	localparam logic [31:0] MASK_EVEN = 32'h0000A0FA;
	localparam logic [31:0] MASK_ODD = 32'h0000A0F2;

	// Reset values
	localparam logic [31:0] CTRL_RESET = 32'h00000000;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [7:0] DIV_RESET = 8'h00;

	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Last prescaler count before a tick, per select code
	function automatic logic [7:0] prescale_last(input logic [2:0] sel);
		logic [7:0] last;
		case (sel)
			3'h0: last = 8'h00;
			3'h1: last = 8'h01;
			3'h2: last = 8'h03;
			3'h3: last = 8'h07;
			3'h4: last = 8'h0F;
			3'h5: last = 8'h1F;
			3'h6: last = 8'h3F;
			default: last = 8'hFF;
		endcase
		return last;
	endfunction

endpackage

/* rtl/sync_two_flop.sv */
// Purpose: Two-stage synchroniser for a pin input.
// Assumes: Input is asynchronous to mclk_in.
// Notes: Only the second stage leaves this module.
`timescale 1ns/10ps
module sync_two_flop (
	input wire logic mclk_in,
	input wire logic reset_n_in,
	input wire logic ce_in,
	input wire logic async_in,
	output logic sync_out
);
	logic stage1_q, stage1_d; // First stage, read only by second
	logic stage2_q, stage2_d; // Settled level

	// Next values, frozen while clock enable is low
	always_comb begin
		stage1_d = ce_in ? async_in : stage1_q;
		stage2_d = ce_in ? stage1_q : stage2_q;
	end

	// Register both stages
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			stage1_q <= 1'b0;
			stage2_q <= 1'b0;
		end else begin
			stage1_q <= stage1_d;
			stage2_q <= stage2_d;
		end
	end

	assign sync_out = stage2_q;
endmodule

/* rtl/prescale_divider.sv */
// Purpose: Input prescaler dividing count events by 1 to 256.
// Assumes: event_in is a one-cycle qualifier on mclk_in.
// Notes: Counter clears while disabled so a restart begins fresh.
`timescale 1ns/10ps
module prescale_divider (
	input wire logic mclk_in,
	input wire logic reset_n_in,
	input wire logic ce_in,
	input wire logic enable_in,
	input wire logic event_in,
	input wire logic [2:0] select_in,
	output logic tick_out
);
	import timer_pkg::*;

	logic [7:0] count_q, count_d; // Events seen since last tick
	logic at_last; // Count reached the selected terminal

	// Tick on the event that completes the selected ratio
	assign at_last = (count_q >= prescale_last(select_in));
	assign tick_out = ce_in & enable_in & event_in & at_last;

	// Next count
	always_comb begin
		count_d = count_q;
		if (ce_in) begin
			if (!enable_in) begin
				count_d = DIV_RESET; // Idle divider restarts
			end else if (event_in) begin
				count_d = at_last ? DIV_RESET : count_q + 8'h01;
			end
		end
	end

	// Register the count
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			count_q <= DIV_RESET;
		end else begin
			count_q <= count_d;
		end
	end
endmodule

/* rtl/timer_pair_control.sv */
// Purpose: Even/odd general-purpose timer pair with control registers.
// Assumes: AXI4-Lite slave on mclk_in; pins ext_clk_in, gate_in are asynchronous.
// Notes: Counters wrap freely; writes to a count win over counting.
`timescale 1ns/10ps
module timer_pair_control (
	input wire logic mclk_in,
	input wire logic reset_n_in,
	input wire logic ce_in,
	input wire logic idle_mode_in,
	input wire logic ext_clk_in,
	input wire logic gate_in,
	input wire logic [timer_pkg::ADDR_W-1:0] awaddr_in,
	input wire logic awvalid_in,
	output logic awready_out,
	input wire logic [31:0] wdata_in,
	input wire logic [3:0] wstrb_in,
	input wire logic wvalid_in,
	output logic wready_out,
	output logic [1:0] bresp_out,
	output logic bvalid_out,
	input wire logic bready_in,
	input wire logic [timer_pkg::ADDR_W-1:0] araddr_in,
	input wire logic arvalid_in,
	output logic arready_out,
	output logic [31:0] rdata_out,
	output logic [1:0] rresp_out,
	output logic rvalid_out,
	input wire logic rready_in
);
	import timer_pkg::*;

	logic wr_fire, rd_fire; // Accepted write and read
	logic bvalid_q, bvalid_d, rvalid_q, rvalid_d; // Pending responses
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d; // Response codes
	logic [31:0] rdata_q, rdata_d; // Read data
	logic [31:0] ctrl_even_q, ctrl_even_d; // Even timer control
	logic [31:0] ctrl_odd_q, ctrl_odd_d; // Odd timer control
	logic [15:0] cnt_even_q, cnt_even_d; // Even count, low half when paired
	logic [15:0] cnt_odd_q, cnt_odd_d; // Odd count, high half when paired
	logic ext_prev_q, ext_prev_d; // Last external clock level
	logic ext_sync, gate_sync, ext_edge; // Synchronised pins
	logic [31:0] lane_mask; // Byte strobes widened to bits
	logic [31:0] ctrl_even_rd, ctrl_odd_rd; // Control read views
	logic wr_ctrl_even, wr_ctrl_odd, wr_cnt_even, wr_cnt_odd; // Write targets
	logic on_e, idle_stop_e, gate_e, tcs_e, paired; // Even fields
	logic on_o, idle_stop_o, gate_o, tcs_o; // Odd fields
	logic [2:0] psel_e, psel_o; // Prescale selects
	logic run_e, run_o, evt_e, evt_o, tick_e, tick_o; // Count path
	logic [31:0] pair_sum; // Joined count plus one

	// Pin synchronisers
	sync_two_flop u_sync_ext (
		.mclk_in(mclk_in),
		.reset_n_in(reset_n_in),
		.ce_in(ce_in),
		.async_in(ext_clk_in),
		.sync_out(ext_sync)
	);
	sync_two_flop u_sync_gate (
		.mclk_in(mclk_in),
		.reset_n_in(reset_n_in),
		.ce_in(ce_in),
		.async_in(gate_in),
		.sync_out(gate_sync)
	);

	// Field decode
	assign on_e = ctrl_even_q[BIT_ON];
	assign idle_stop_e = ctrl_even_q[BIT_IDLE_STOP];
	assign tcs_e = ctrl_even_q[BIT_CLK_SRC];
	assign gate_e = ctrl_even_q[BIT_GATE] & ~tcs_e;
	assign psel_e = ctrl_even_q[PRESCALE_MSB:PRESCALE_LSB];
	assign paired = ctrl_even_q[BIT_PAIR];
	assign on_o = ctrl_odd_q[BIT_ON];
	assign idle_stop_o = ctrl_odd_q[BIT_IDLE_STOP];
	assign tcs_o = ctrl_odd_q[BIT_CLK_SRC];
	assign gate_o = ctrl_odd_q[BIT_GATE] & ~tcs_o;
	assign psel_o = ctrl_odd_q[PRESCALE_MSB:PRESCALE_LSB];

	// Rising edge of the external clock after synchronising
	assign ext_edge = ext_sync & ~ext_prev_q;

	// Run conditions; paired odd idle-stop also halts the pair
	assign run_e = on_e & ~(idle_mode_in & idle_stop_e) & ~(paired & idle_mode_in & idle_stop_o);
	assign run_o = ~paired & on_o & ~(idle_mode_in & idle_stop_o);

	// Count event source ahead of the prescaler
	assign evt_e = tcs_e ? ext_edge : (gate_e ? gate_sync : 1'b1);
	assign evt_o = tcs_o ? ext_edge : (gate_o ? gate_sync : 1'b1);

	// Prescalers
	prescale_divider u_div_even (
		.mclk_in(mclk_in),
		.reset_n_in(reset_n_in),
		.ce_in(ce_in),
		.enable_in(run_e),
		.event_in(evt_e),
		.select_in(psel_e),
		.tick_out(tick_e)
	);
	prescale_divider u_div_odd (
		.mclk_in(mclk_in),
		.reset_n_in(reset_n_in),
		.ce_in(ce_in),
		.enable_in(run_o),
		.event_in(evt_o),
		.select_in(psel_o),
		.tick_out(tick_o)
	);

	// Bus handshakes; everything stalls while clock enable is low
	assign awready_out = ce_in & awvalid_in & wvalid_in & ~bvalid_q;
	assign wready_out = awready_out;
	assign arready_out = ce_in & ~rvalid_q;
	assign wr_fire = awvalid_in & wvalid_in & awready_out;
	assign rd_fire = arvalid_in & arready_out;
	assign bvalid_out = bvalid_q & ce_in;
	assign rvalid_out = rvalid_q & ce_in;
	assign bresp_out = bresp_q;
	assign rresp_out = rresp_q;
	assign rdata_out = rdata_q;
	assign lane_mask = {{8{wstrb_in[3]}}, {8{wstrb_in[2]}}, {8{wstrb_in[1]}}, {8{wstrb_in[0]}}};

	// Write decode
	assign wr_ctrl_even = wr_fire & (awaddr_in == OFF_CTRL_EVEN);
	assign wr_ctrl_odd = wr_fire & (awaddr_in == OFF_CTRL_ODD);
	assign wr_cnt_even = wr_fire & (awaddr_in == OFF_COUNT_EVEN);
	assign wr_cnt_odd = wr_fire & (awaddr_in == OFF_COUNT_ODD);

	// Control read views: gate reads zero on external clock
	always_comb begin
		ctrl_even_rd = ctrl_even_q & MASK_EVEN;
		ctrl_odd_rd = ctrl_odd_q & MASK_ODD;
		if (tcs_e) begin
			ctrl_even_rd[BIT_GATE] = 1'b0;
		end
		if (tcs_o) begin
			ctrl_odd_rd[BIT_GATE] = 1'b0;
		end
	end

	// Bus response next values
	always_comb begin
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		if (ce_in) begin
			// Retire answers the master has taken
			if (bvalid_q & bready_in) begin
				bvalid_d = 1'b0;
			end
			if (rvalid_q & rready_in) begin
				rvalid_d = 1'b0;
			end
			// Write answer
			if (wr_fire) begin
				bvalid_d = 1'b1;
				bresp_d = (wr_ctrl_even | wr_ctrl_odd | wr_cnt_even | wr_cnt_odd) ? RESP_OKAY : RESP_SLVERR;
			end
			// Read answer
			if (rd_fire) begin
				rvalid_d = 1'b1;
				rresp_d = RESP_OKAY;
				case (araddr_in)
					OFF_CTRL_EVEN: rdata_d = ctrl_even_rd;
					OFF_COUNT_EVEN: rdata_d = {16'h0000, cnt_even_q};
					OFF_CTRL_ODD: rdata_d = ctrl_odd_rd;
					OFF_COUNT_ODD: rdata_d = {16'h0000, cnt_odd_q};
					default: begin
						rdata_d = 32'h00000000;
						rresp_d = RESP_SLVERR;
					end
				endcase
			end
		end
	end

	// Register bus response state
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			rvalid_q <= 1'b0;
			rresp_q <= RESP_OKAY;
			rdata_q <= 32'h00000000;
		end else begin
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
		end
	end

	assign pair_sum = {cnt_odd_q, cnt_even_q} + 32'h00000001;

	// Control and count next values
	always_comb begin
		ctrl_even_d = ctrl_even_q;
		ctrl_odd_d = ctrl_odd_q;
		cnt_even_d = cnt_even_q;
		cnt_odd_d = cnt_odd_q;
		ext_prev_d = ce_in ? ext_sync : ext_prev_q;
		// Only implemented bits take writes
		if (wr_ctrl_even) begin
			ctrl_even_d = (ctrl_even_q & ~(MASK_EVEN & lane_mask)) | (wdata_in & MASK_EVEN & lane_mask);
		end
		if (wr_ctrl_odd) begin
			ctrl_odd_d = (ctrl_odd_q & ~(MASK_ODD & lane_mask)) | (wdata_in & MASK_ODD & lane_mask);
		end
		// Counting
		if (paired) begin
			if (tick_e) begin
				cnt_even_d = pair_sum[15:0];
				cnt_odd_d = pair_sum[31:16];
			end
		end else begin
			if (tick_e) begin
				cnt_even_d = cnt_even_q + 16'h0001;
			end
			if (tick_o) begin
				cnt_odd_d = cnt_odd_q + 16'h0001;
			end
		end
		// Software writes to counts win
		if (wr_cnt_even) begin
			cnt_even_d = (cnt_even_q & ~lane_mask[15:0]) | (wdata_in[15:0] & lane_mask[15:0]);
		end
		if (wr_cnt_odd) begin
			cnt_odd_d = (cnt_odd_q & ~lane_mask[15:0]) | (wdata_in[15:0] & lane_mask[15:0]);
		end
	end

	// Register control and counts
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ctrl_even_q <= CTRL_RESET;
			ctrl_odd_q <= CTRL_RESET;
			cnt_even_q <= COUNT_RESET;
			cnt_odd_q <= COUNT_RESET;
			ext_prev_q <= 1'b0;
		end else begin
			ctrl_even_q <= ctrl_even_d;
			ctrl_odd_q <= ctrl_odd_d;
			cnt_even_q <= cnt_even_d;
			cnt_odd_q <= cnt_odd_d;
			ext_prev_q <= ext_prev_d;
		end
	end

	// Checks
	AST_OFF_HOLDS: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(!on_e && !wr_cnt_even) |=> (cnt_even_q == $past(cnt_even_q)))
		else $error("even count moved while disabled");
	AST_IDLE_STOP: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(idle_mode_in && idle_stop_e && !wr_cnt_even) |=> (cnt_even_q == $past(cnt_even_q)))
		else $error("even count moved in idle with stop set");
	AST_ODD_IDLE: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(paired && idle_mode_in && idle_stop_o && !wr_cnt_even) |=> (cnt_even_q == $past(cnt_even_q)))
		else $error("pair ran in idle with odd stop set");
	AST_GATE_ACCUMULATE_ENABLE_READ: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(rd_fire && araddr_in == OFF_CTRL_EVEN && tcs_e) |=> !rdata_q[BIT_GATE])
		else $error("gate bit read as one on external clock");
	AST_GATE_BLOCK: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(gate_e && !gate_sync && !wr_cnt_even) |=> (cnt_even_q == $past(cnt_even_q)))
		else $error("gated count moved with gate low");
	AST_PRESCALE_1: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(ce_in && run_e && psel_e == 3'h0 && !tcs_e && !gate_e && !wr_cnt_even)
		|=> (cnt_even_q == $past(cnt_even_q) + 16'h0001))
		else $error("divide by one did not count every cycle");
	AST_PRESCALE_2: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(tick_e && psel_e == 3'h1) |=> !tick_e)
		else $error("divide by two ticked twice in a row");
	AST_ODD_NO_PAIR: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(rd_fire && araddr_in == OFF_CTRL_ODD) |=> !rdata_q[BIT_PAIR])
		else $error("odd pair bit read as one");
	AST_ODD_IGNORED: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(paired && !on_o && tick_e && cnt_even_q == 16'hFFFF && !wr_cnt_odd)
		|=> (cnt_odd_q == $past(cnt_odd_q) + 16'h0001))
		else $error("odd half ignored even settings in pair");
	AST_PAIR_CARRY: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(paired && tick_e && cnt_even_q == 16'hFFFF && !wr_cnt_even && !wr_cnt_odd)
		|=> (cnt_even_q == 16'h0000 && cnt_odd_q == $past(cnt_odd_q) + 16'h0001))
		else $error("pair carry missing");
	AST_EXT_CLOCK: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(tcs_e && !ext_edge && !wr_cnt_even) |=> (cnt_even_q == $past(cnt_even_q)))
		else $error("external clock mode counted without edge");
	AST_RSVD_ZERO: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(rd_fire && araddr_in == OFF_CTRL_EVEN) |=> ((rdata_q & ~MASK_EVEN) == 32'h00000000))
		else $error("unimplemented control bit read as one");
	// Clock enable low freezes both counts
	AST_CE_FREEZE: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(!ce_in) |=> (cnt_even_q == $past(cnt_even_q) && cnt_odd_q == $past(cnt_odd_q)))
		else $error("count moved while clock enable low");
	// Paired odd half moves only on the even carry
	AST_PAIR_ODD_HOLD: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(paired && !wr_cnt_odd && !(tick_e && cnt_even_q == 16'hFFFF)) |=> (cnt_odd_q == $past(cnt_odd_q)))
		else $error("odd half counted on its own in pair");
	// Unpaired odd timer holds while its enable is clear
	AST_ODD_OFF_HOLDS: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(!paired && !on_o && !wr_cnt_odd) |=> (cnt_odd_q == $past(cnt_odd_q)))
		else $error("odd count moved while disabled");
endmodule

/* test/general_timer_control_tb.sv */
// Purpose: Self-checking bench for the paired timer block over its register bus.
// Assumes: Bench drives every port itself; ce_in is high except in its own check.
// Notes: Count deltas are judged against the bench's own cycle count.
`timescale 1ns/10ps
module general_timer_control_tb;
	import timer_pkg::*;

	// Stimulus, all driven by non-blocking assignment after a rising edge
	logic mclk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic ce_in = 1'b1;
	logic idle_mode_in = 1'b0;
	logic ext_clk_in = 1'b0;
	logic gate_in = 1'b0;
	logic [ADDR_W-1:0] awaddr_in = '0;
	logic awvalid_in = 1'b0;
	logic [31:0] wdata_in = '0;
	logic [3:0] wstrb_in = 4'h0;
	logic wvalid_in = 1'b0;
	logic bready_in = 1'b0;
	logic [ADDR_W-1:0] araddr_in = '0;
	logic arvalid_in = 1'b0;
	logic rready_in = 1'b0;
	// Responses from the block
	logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
	logic [1:0] bresp_out, rresp_out;
	logic [31:0] rdata_out;
	logic aw_w_ready; // Both write channels ready
	// Bookkeeping
	int num_errors = 0;
	int check_count = 0;
	int cyc = 0;
	int t_take;
	logic [31:0] c1, c2, rv;
	logic [1:0] rr;

	// 250 MHz clock and free-running cycle count
	always #2 mclk_in = ~mclk_in;
	always @(posedge mclk_in) cyc <= cyc + 1;
	assign aw_w_ready = awready_out & wready_out;

	timer_pair_control dut (
		.mclk_in(mclk_in), .reset_n_in(reset_n_in), .ce_in(ce_in), .idle_mode_in(idle_mode_in),
		.ext_clk_in(ext_clk_in), .gate_in(gate_in), .awaddr_in(awaddr_in), .awvalid_in(awvalid_in),
		.awready_out(awready_out), .wdata_in(wdata_in), .wstrb_in(wstrb_in), .wvalid_in(wvalid_in),
		.wready_out(wready_out), .bresp_out(bresp_out), .bvalid_out(bvalid_out), .bready_in(bready_in),
		.araddr_in(araddr_in), .arvalid_in(arvalid_in), .arready_out(arready_out),
		.rdata_out(rdata_out), .rresp_out(rresp_out), .rvalid_out(rvalid_out), .rready_in(rready_in)
	);

	// Verdict and end of run
	task automatic finish_test;
		$display("Checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Exact comparison of one value
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Count delta times divisor must lie strictly within one divisor of the gap
	task automatic chk_near(input logic [31:0] delta, input int gap, input int div);
		int prod;
		prod = int'(delta[15:0]) * div;
		check_count++;
		if (prod <= gap - div || prod >= gap + div) begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, prod, gap);
		end
	endtask

	// Bounded wait until a signal is high before a rising edge, then take that edge
	task automatic wait_hi(ref logic sig);
		int n;
		n = 0;
		@(negedge mclk_in);
		while (sig !== 1'b1) begin
			n++;
			if (n > 200) begin
				num_errors++;
				$display("[ERR] %0t got %h exp %h", $time, sig, 1'b1);
				finish_test();
			end
			@(negedge mclk_in);
		end
		@(posedge mclk_in);
	endtask

	// Register write: address and data offered together, response checked
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge mclk_in);
		awaddr_in <= a;
		wdata_in <= d;
		wstrb_in <= 4'hF;
		awvalid_in <= 1'b1;
		wvalid_in <= 1'b1;
		bready_in <= 1'b1;
		wait_hi(aw_w_ready);
		awvalid_in <= 1'b0;
		wvalid_in <= 1'b0;
		wait_hi(bvalid_out);
		bready_in <= 1'b0;
		chk({30'h0, bresp_out}, {30'h0, er});
	endtask

	// Register read; records the cycle at which the request was taken
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge mclk_in);
		araddr_in <= a;
		arvalid_in <= 1'b1;
		rready_in <= 1'b1;
		wait_hi(arready_out);
		t_take = cyc;
		arvalid_in <= 1'b0;
		wait_hi(rvalid_out);
		rready_in <= 1'b0;
		d = rdata_out;
		r = rresp_out;
	endtask

	// Read and compare data with an OKAY response
	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
		rd(a, rv, rr);
		chk(rv, exp);
		chk({30'h0, rr}, {30'h0, RESP_OKAY});
	endtask

	// Two even-count reads gap cycles apart; c1/c2 hold them, returns the gap
	task automatic sample(input int wait_cyc, output int gap);
		int t1;
		rd(OFF_COUNT_EVEN, c1, rr);
		t1 = t_take;
		repeat (wait_cyc) @(posedge mclk_in);
		rd(OFF_COUNT_EVEN, c2, rr);
		gap = t_take - t1;
	endtask

	// Reset values, unused bits and unmapped addresses
	task automatic t_regs;
		rd_chk(OFF_CTRL_EVEN, 32'h0);
		rd_chk(OFF_CTRL_ODD, 32'h0);
		rd_chk(OFF_COUNT_EVEN, 32'h0);
		wr(OFF_CTRL_EVEN, 32'hFFFFFFFF, RESP_OKAY);
		rd_chk(OFF_CTRL_EVEN, 32'h0000A07A);
		wr(OFF_CTRL_ODD, 32'hFFFFFFFF, RESP_OKAY);
		rd_chk(OFF_CTRL_ODD, 32'h0000A072);
		wr(OFF_CTRL_EVEN, 32'h00000080, RESP_OKAY);
		rd_chk(OFF_CTRL_EVEN, 32'h00000080);
		wr(OFF_CTRL_ODD, 32'h0, RESP_OKAY);
		wr(8'h10, 32'hFFFFFFFF, RESP_SLVERR);
		rd(8'h10, rv, rr);
		chk(rv, 32'h0);
		chk({30'h0, rr}, {30'h0, RESP_SLVERR});
	endtask

	// Every prescale code on the bus clock, then enable cleared
	task automatic t_prescale;
		int div, gap;
		for (int s = 0; s < 8; s++) begin
			div = (s == 7) ? 256 : (1 << s);
			wr(OFF_CTRL_EVEN, 32'h0, RESP_OKAY);
			wr(OFF_CTRL_EVEN, 32'h8000 | (s << 4), RESP_OKAY);
			sample(4 * div, gap);
			chk_near(c2 - c1, gap, div);
		end
		wr(OFF_CTRL_EVEN, 32'h0, RESP_OKAY);
		@(posedge mclk_in);
		sample(20, gap);
		chk(c2, c1);
	endtask

	// Idle stop, gating and the external clock
	task automatic t_modes;
		int gap;
		idle_mode_in <= 1'b1;
		wr(OFF_CTRL_EVEN, 32'h0000A000, RESP_OKAY);
		sample(20, gap);
		chk(c2, c1);
		wr(OFF_CTRL_EVEN, 32'h00008000, RESP_OKAY);
		sample(20, gap);
		chk_near(c2 - c1, gap, 1);
		// Ten edges with clock enable low must not count
		rd(OFF_COUNT_EVEN, c1, rr);
		gap = t_take;
		ce_in <= 1'b0;
		repeat (10) @(posedge mclk_in);
		ce_in <= 1'b1;
		rd(OFF_COUNT_EVEN, c2, rr);
		chk_near(c2 - c1, t_take - gap - 10, 1);
		idle_mode_in <= 1'b0;
		wr(OFF_CTRL_EVEN, 32'h00008080, RESP_OKAY);
		sample(20, gap);
		chk(c2, c1);
		gate_in <= 1'b1;
		repeat (6) @(posedge mclk_in);
		sample(20, gap);
		chk_near(c2 - c1, gap, 1);
		gate_in <= 1'b0;
		wr(OFF_CTRL_EVEN, 32'h00008082, RESP_OKAY);
		rd_chk(OFF_CTRL_EVEN, 32'h00008002);
		rd(OFF_COUNT_EVEN, c1, rr);
		repeat (5) begin
			repeat (4) @(posedge mclk_in);
			ext_clk_in <= 1'b1;
			repeat (4) @(posedge mclk_in);
			ext_clk_in <= 1'b0;
		end
		repeat (8) @(posedge mclk_in);
		rd(OFF_COUNT_EVEN, c2, rr);
		chk((c2 - c1) & 32'hFFFF, 32'h5);
		wr(OFF_CTRL_EVEN, 32'h0, RESP_OKAY);
	endtask

	// Pair: carry into the odd half, odd settings ignored, odd idle stop
	task automatic t_pair;
		int gap;
		wr(OFF_COUNT_EVEN, 32'h0000FFF0, RESP_OKAY);
		wr(OFF_COUNT_ODD, 32'h0, RESP_OKAY);
		wr(OFF_CTRL_ODD, 32'h00000070, RESP_OKAY);
		wr(OFF_CTRL_EVEN, 32'h00008008, RESP_OKAY);
		repeat (40) @(posedge mclk_in);
		wr(OFF_CTRL_EVEN, 32'h00000008, RESP_OKAY);
		rd_chk(OFF_COUNT_ODD, 32'h1);
		wr(OFF_CTRL_ODD, 32'h00002000, RESP_OKAY);
		wr(OFF_CTRL_EVEN, 32'h00008008, RESP_OKAY);
		idle_mode_in <= 1'b1;
		repeat (2) @(posedge mclk_in);
		sample(20, gap);
		chk(c2, c1);
		idle_mode_in <= 1'b0;
	endtask

	// Main sequence
	initial begin
		repeat (20) @(posedge mclk_in);
		reset_n_in <= 1'b1;
		t_regs();
		t_prescale();
		t_modes();
		t_pair();
		finish_test();
	end
endmodule
